// file: sdou_top.v
// Purpose: Stencil test, depth test and occlusion query stage for one fragment stream
// Assumes: Buffer reads are supplied with the fragment; one fragment per cycle at most
// Notes:   Overview of operation below; registers over AXI4-Lite
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "sdou_defines.vh"
module sdou_top #(
	parameter SW = 8,
	parameter DW = 24,
	parameter XW = 12,
	parameter NS = 4
) (
	// Clock and reset
	input wire              aclk,
	input wire              aresetn,
	// AXI4-Lite write address and data
	input wire              s_axi_awvalid,
	output wire             s_axi_awready,
	input wire [7:0]        s_axi_awaddr,
	input wire              s_axi_wvalid,
	output wire             s_axi_wready,
	input wire [31:0]       s_axi_wdata,
	input wire [3:0]        s_axi_wstrb,
	// AXI4-Lite write response
	output reg              s_axi_bvalid,
	input wire              s_axi_bready,
	output reg [1:0]        s_axi_bresp,
	// AXI4-Lite read
	input wire              s_axi_arvalid,
	output wire             s_axi_arready,
	input wire [7:0]        s_axi_araddr,
	output reg              s_axi_rvalid,
	input wire              s_axi_rready,
	output reg [31:0]       s_axi_rdata,
	output reg [1:0]        s_axi_rresp,
	// Incoming fragment with buffer contents already read
	input wire              frag_valid,
	output wire             frag_ready,
	input wire [XW-1:0]     frag_x,
	input wire [XW-1:0]     frag_y,
	input wire [DW-1:0]     frag_z,
	input wire              frag_polygon,
	input wire              frag_back,
	input wire [NS-1:0]     frag_cover,
	input wire [SW-1:0]     frag_stencil_old,
	input wire [DW-1:0]     frag_depth_old,
	// Surviving fragment to the next stage
	output reg              out_valid,
	output reg [XW-1:0]     out_x,
	output reg [XW-1:0]     out_y,
	output reg [DW-1:0]     out_z,
	output reg [NS-1:0]     out_cover,
	// Stencil and depth buffer writes
	output reg              stencil_we,
	output reg [SW-1:0]     stencil_wdata,
	output reg              depth_we,
	output reg [DW-1:0]     depth_wdata,
	output reg [XW-1:0]     wr_x,
	output reg [XW-1:0]     wr_y,
	// Pipeline state for query end and early-test mode
	input wire              upstream_idle,
	output wire             early_tests
);
	// Registers
	reg [6:0]    ctrl_q;
	reg [2:0]    sfunc_q   [0:1];
	reg [7:0]    sref_q    [0:1];
	reg [SW-1:0] smask_q   [0:1];
	reg [8:0]    sop_q     [0:1];
	reg [2:0]    dfunc_q;
	reg [DW-1:0] dnear_q;
	reg [DW-1:0] dfar_q;
	reg [1:0]    qkind_q;
	reg          qactive_q;
	reg          qdrain_q;
	reg          qavail_q;
	reg [31:0]   qcount_q;
	reg          qflag_q;
	reg [31:0]   qresult_q;

	// Write channel: both address and data needed, taken together
	wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
	assign s_axi_arready = rd_go;
	wire [1:0] face_w = s_axi_wdata[31:30];
	wire wmap = (s_axi_awaddr <= `SDOU_REG_QCMD) && (s_axi_awaddr[1:0] == 2'h0);

	// Fragment stage: single-cycle, results registered; never stalls
	assign frag_ready  = 1'b1;
	assign early_tests = ctrl_q[`SDOU_CTRL_EARLY];
	wire fire = frag_valid;
	wire face = frag_polygon & frag_back;

	// Clamp reference, then mask
	wire [7:0]    ref_raw = sref_q[face];
	wire [SW-1:0] ref_cl  = (SW < 8 && (ref_raw >> SW) != 8'h00) ? {SW{1'b1}} : ref_raw[SW-1:0];
	wire [SW-1:0] s_lhs   = ref_cl & smask_q[face];
	wire [SW-1:0] s_rhs   = frag_stencil_old & smask_q[face];
	wire          s_cmp;
	sdou_compare #(.W(SW)) u_scmp (
		.lhs  (s_lhs),
		.rhs  (s_rhs),
		.func (sfunc_q[face]),
		.pass (s_cmp)
	);
	wire s_on   = ctrl_q[`SDOU_CTRL_STEN] & ctrl_q[`SDOU_CTRL_SBUF];
	wire s_pass = ~s_on | s_cmp;

	// Depth compare with optional clamp
	wire [DW-1:0] dmin = (dnear_q < dfar_q) ? dnear_q : dfar_q;
	wire [DW-1:0] dmax = (dnear_q < dfar_q) ? dfar_q : dnear_q;
	wire [DW-1:0] z_cl = !ctrl_q[`SDOU_CTRL_DCLAMP] ? frag_z :
		(frag_z < dmin) ? dmin : (frag_z > dmax) ? dmax : frag_z;
	wire d_cmp;
	sdou_compare #(.W(DW)) u_dcmp (
		.lhs  (z_cl),
		.rhs  (frag_depth_old),
		.func (dfunc_q),
		.pass (d_cmp)
	);
	wire d_on   = ctrl_q[`SDOU_CTRL_DEN] & ctrl_q[`SDOU_CTRL_DBUF];
	wire d_pass = ~d_on | d_cmp;

	// Select action: fail, depth-fail, pass
	wire [8:0] ops = sop_q[face];
	wire [2:0] act = !s_pass ? ops[2:0] : !d_pass ? ops[5:3] : ops[8:6];
	wire [SW-1:0] s_new;
	sdou_stencil_action #(.W(SW)) u_sact (
		.cur     (frag_stencil_old),
		.ref_val (ref_cl),
		.act     (act),
		.nxt     (s_new)
	);
	wire keep_frag = s_pass & d_pass;

	// Samples passing this fragment
	reg [31:0] ncov;
	integer i;
	always @* begin
		ncov = 32'h0;
		for (i = 0; i < NS; i = i + 1)
			ncov = ncov + {31'h0, frag_cover[i]};
	end
	wire [31:0] add_w = ctrl_q[`SDOU_CTRL_MSAA] ? ncov : 32'h1;
	wire        any_w = fire & keep_frag & (~ctrl_q[`SDOU_CTRL_MSAA] | (|frag_cover));

	// Fragment outputs; writes leave in arrival order, one per cycle
	always @(posedge aclk) begin
		if (!aresetn) begin
			out_valid     <= 1'b0;
			out_x         <= {XW{1'b0}};
			out_y         <= {XW{1'b0}};
			out_z         <= {DW{1'b0}};
			out_cover     <= {NS{1'b0}};
			stencil_we    <= 1'b0;
			stencil_wdata <= {SW{1'b0}};
			depth_we      <= 1'b0;
			depth_wdata   <= {DW{1'b0}};
			wr_x          <= {XW{1'b0}};
			wr_y          <= {XW{1'b0}};
		end else begin
			out_valid     <= fire & keep_frag;
			out_x         <= frag_x;
			out_y         <= frag_y;
			out_z         <= z_cl;
			out_cover     <= frag_cover;
			stencil_we    <= fire & s_on & (s_new != frag_stencil_old);
			stencil_wdata <= s_new;
			depth_we      <= fire & d_on & keep_frag;
			depth_wdata   <= z_cl;
			wr_x          <= frag_x;
			wr_y          <= frag_y;
		end
	end

	// Register writes and queries
	wire is_cmd = wr_go & wmap & (s_axi_awaddr == `SDOU_REG_QCMD) & s_axi_wstrb[0];
	wire q_begin = is_cmd & s_axi_wdata[`SDOU_QCMD_BEGIN];
	wire q_end   = is_cmd & s_axi_wdata[`SDOU_QCMD_END] & qactive_q;
	integer f;
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q   <= `SDOU_CTRL_RESET;
			dfunc_q  <= `SDOU_CMP_LESS;
			dnear_q  <= {DW{1'b0}};
			dfar_q   <= {DW{1'b1}};
			for (f = 0; f < 2; f = f + 1) begin
				sfunc_q[f] <= `SDOU_CMP_ALWAYS;
				sref_q[f]  <= 8'h00;
				smask_q[f] <= {SW{1'b1}};
				sop_q[f]   <= 9'h000;
			end
			qkind_q  <= `SDOU_QKIND_COUNT;
			qactive_q <= 1'b0;
			qdrain_q <= 1'b0;
			qavail_q <= 1'b0;
			qcount_q <= 32'h0;
			qflag_q  <= 1'b0;
			qresult_q <= 32'h0;
		end else begin
			if (wr_go && wmap && s_axi_wstrb == 4'hF) begin
				case (s_axi_awaddr)
					`SDOU_REG_CTRL:  ctrl_q <= s_axi_wdata[6:0];
					`SDOU_REG_DEPTH: dfunc_q <= s_axi_wdata[2:0];
					`SDOU_REG_RANGE: begin
						dnear_q <= {s_axi_wdata[15:0], {(DW-16){1'b0}}};
						dfar_q  <= {s_axi_wdata[31:16], {(DW-16){1'b0}}};
					end
					default: ;
				endcase
				for (f = 0; f < 2; f = f + 1) begin
					if (face_w[f]) begin
						// Either address honours the selector, so a both-faces write loads both sets
						if (s_axi_awaddr == `SDOU_REG_SFUNC_F || s_axi_awaddr == `SDOU_REG_SFUNC_B) begin
							sfunc_q[f] <= s_axi_wdata[26:24];
							sref_q[f]  <= s_axi_wdata[23:16];
							smask_q[f] <= s_axi_wdata[SW-1:0];
						end
						if (s_axi_awaddr == `SDOU_REG_SOP_F || s_axi_awaddr == `SDOU_REG_SOP_B)
							sop_q[f] <= s_axi_wdata[8:0];
					end
				end
			end
			// Count and flag while active; begin wins over a same-cycle fragment
			if (q_begin) begin
				qkind_q   <= s_axi_wdata[3:2];
				qactive_q <= 1'b1;
				qdrain_q  <= 1'b0;
				qavail_q  <= 1'b0;
				qcount_q  <= 32'h0;
				qflag_q   <= 1'b0;
			end else begin
				if (qactive_q && fire && keep_frag)
					qcount_q <= qcount_q + add_w;
				if (qactive_q && any_w)
					qflag_q <= 1'b1;
				if (q_end)
					qdrain_q <= 1'b1;
				// Result waits for the source and the output register to drain
				if (qdrain_q && upstream_idle && !frag_valid && !out_valid) begin
					qactive_q <= 1'b0;
					qdrain_q  <= 1'b0;
					qavail_q  <= 1'b1;
					qresult_q <= (qkind_q == `SDOU_QKIND_COUNT) ? qcount_q : {31'h0, qflag_q};
				end
			end
		end
	end

	// Write response and read data
	wire [SW-1:0] rd_ref_f = (SW < 8 && (sref_q[0] >> SW) != 8'h00) ? {SW{1'b1}} : sref_q[0][SW-1:0];
	wire [SW-1:0] rd_ref_b = (SW < 8 && (sref_q[1] >> SW) != 8'h00) ? {SW{1'b1}} : sref_q[1][SW-1:0];
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SDOU_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= `SDOU_RESP_OKAY;
		end else begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wmap ? `SDOU_RESP_OKAY : `SDOU_RESP_SLVERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `SDOU_RESP_OKAY;
				case (s_axi_araddr)
					`SDOU_REG_CTRL:    s_axi_rdata <= {25'h0, ctrl_q};
					`SDOU_REG_SFUNC_F: s_axi_rdata <= {5'h0, sfunc_q[0], 8'h0, {(16-SW){1'b0}}, smask_q[0]} |
						({{(32-SW){1'b0}}, rd_ref_f} << 16);
					`SDOU_REG_SFUNC_B: s_axi_rdata <= {5'h0, sfunc_q[1], 8'h0, {(16-SW){1'b0}}, smask_q[1]} |
						({{(32-SW){1'b0}}, rd_ref_b} << 16);
					`SDOU_REG_SOP_F:   s_axi_rdata <= {23'h0, sop_q[0]};
					`SDOU_REG_SOP_B:   s_axi_rdata <= {23'h0, sop_q[1]};
					`SDOU_REG_DEPTH:   s_axi_rdata <= {29'h0, dfunc_q};
					`SDOU_REG_RANGE:   s_axi_rdata <= {dfar_q[DW-1:DW-16], dnear_q[DW-1:DW-16]};
					`SDOU_REG_QCMD:    s_axi_rdata <= {28'h0, qkind_q, 2'h0};
					`SDOU_REG_QSTAT:   s_axi_rdata <= {29'h0, qdrain_q, qactive_q, qavail_q};
					`SDOU_REG_QRESULT: s_axi_rdata <= qresult_q;
					`SDOU_REG_STCFG:   s_axi_rdata <= SW;
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= `SDOU_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // sdou_top

// file: sdou_defines.vh
// Purpose: Constants for the stencil, depth and occlusion stage
// Assumes: Included by every design file of the block
// Notes:   Offsets are byte addresses on the register bus
`ifndef SDOU_DEFINES_VH
`define SDOU_DEFINES_VH
// Register byte offsets
`define SDOU_REG_CTRL      8'h00
`define SDOU_REG_SFUNC_F   8'h04
`define SDOU_REG_SFUNC_B   8'h08
`define SDOU_REG_SOP_F     8'h0C
`define SDOU_REG_SOP_B     8'h10
`define SDOU_REG_DEPTH     8'h14
`define SDOU_REG_RANGE     8'h18
`define SDOU_REG_QCMD      8'h1C
`define SDOU_REG_QSTAT     8'h20
`define SDOU_REG_QRESULT   8'h24
`define SDOU_REG_STCFG     8'h28
// Stencil config write face selector, bits 31:30 of the function and action words
`define SDOU_FACE_FRONT    2'h1
`define SDOU_FACE_BACK     2'h2
`define SDOU_FACE_BOTH     2'h3
// Compare functions
`define SDOU_CMP_NEVER     3'h0
`define SDOU_CMP_LESS      3'h1
`define SDOU_CMP_EQUAL     3'h2
`define SDOU_CMP_LESS_OR_EQUAL    3'h3
`define SDOU_CMP_GREATER   3'h4
`define SDOU_CMP_DIFFERS   3'h5
`define SDOU_CMP_GREATER_OR_SAME    3'h6
`define SDOU_CMP_ALWAYS    3'h7
// Stencil actions
`define SDOU_ACT_KEEP      3'h0
`define SDOU_ACT_ZERO      3'h1
`define SDOU_ACT_REPLACE   3'h2
`define SDOU_ACT_INC_SAT   3'h3
`define SDOU_ACT_DEC_SAT   3'h4
`define SDOU_ACT_INVERT    3'h5
`define SDOU_ACT_INC_WRAP  3'h6
`define SDOU_ACT_DEC_WRAP  3'h7
// Control bits
`define SDOU_CTRL_STEN     0
`define SDOU_CTRL_DEN      1
`define SDOU_CTRL_DCLAMP   2
`define SDOU_CTRL_SBUF     3
`define SDOU_CTRL_DBUF     4
`define SDOU_CTRL_MSAA     5
`define SDOU_CTRL_EARLY    6
// Control reset: both buffers attached, every test off
`define SDOU_CTRL_RESET    7'h18
// Query commands and kinds
`define SDOU_QCMD_BEGIN    0
`define SDOU_QCMD_END      1
`define SDOU_QKIND_COUNT   2'h0
`define SDOU_QKIND_ANY     2'h1
`define SDOU_QKIND_LOOSE   2'h2
// Bus responses
`define SDOU_RESP_OKAY     2'h0
`define SDOU_RESP_SLVERR   2'h2
`endif

// file: sdou_compare.v
// Purpose: Eight-way unsigned compare of a fragment value against a stored value
// Assumes: Both operands already masked or clamped by the caller
// Notes:   Shared by the stencil and depth tests
`timescale 1ns/1ps
`include "sdou_defines.vh"
module sdou_compare #(
	parameter W = 8
) (
	// Operands
	input wire [W-1:0] lhs,
	input wire [W-1:0] rhs,
	// Function and result
	input wire [2:0]   func,
	output reg         pass
);
	always @* begin
		case (func)
			`SDOU_CMP_NEVER:   pass = 1'b0;
			`SDOU_CMP_LESS:    pass = lhs <  rhs;
			`SDOU_CMP_EQUAL:   pass = lhs == rhs;
			`SDOU_CMP_LESS_OR_EQUAL:  pass = lhs <= rhs;
			`SDOU_CMP_GREATER: pass = lhs >  rhs;
			`SDOU_CMP_DIFFERS: pass = lhs != rhs;
			`SDOU_CMP_GREATER_OR_SAME:  pass = lhs >= rhs;
			default:           pass = 1'b1;
		endcase
	end
endmodule // sdou_compare

// file: sdou_stencil_action.v
// Purpose: Apply one of eight stencil update actions
// Assumes: Value is unsigned, W bits wide
// Notes:   Saturating and wrapping forms differ only at 0 and all ones
`timescale 1ns/1ps
`include "sdou_defines.vh"
module sdou_stencil_action #(
	parameter W = 8
) (
	// Inputs
	input wire [W-1:0] cur,
	input wire [W-1:0] ref_val,
	input wire [2:0]   act,
	// Result
	output reg [W-1:0] nxt
);
	wire max_w = &cur;
	wire zero_w = ~|cur;
	always @* begin
		case (act)
			`SDOU_ACT_ZERO:     nxt = {W{1'b0}};
			`SDOU_ACT_REPLACE:  nxt = ref_val;
			`SDOU_ACT_INC_SAT:  nxt = max_w ? cur : cur + 1'b1;
			`SDOU_ACT_DEC_SAT:  nxt = zero_w ? cur : cur - 1'b1;
			`SDOU_ACT_INVERT:   nxt = ~cur;
			`SDOU_ACT_INC_WRAP: nxt = cur + 1'b1;
			`SDOU_ACT_DEC_WRAP: nxt = cur - 1'b1;
			default:            nxt = cur;
		endcase
	end
endmodule // sdou_stencil_action

// file: sdou_chk_sva.sv
// Purpose: Port checks for the stencil, depth and query stage
// Assumes: Bound to every instance of the top module
// Notes:   Stencil results hang on register state, so the bench judges them
`timescale 1ns/1ps
module sdou_chk #(parameter DW = 24, parameter XW = 12) (
	// Register bus
	input wire          aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_awready, s_axi_bvalid, s_axi_bready,
	input wire          s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
	input wire [1:0]    s_axi_bresp,
	input wire [31:0]   s_axi_rdata,
	// Fragment path
	input wire          frag_valid, out_valid, stencil_we, depth_we,
	input wire [XW-1:0] out_x, out_y, wr_x, wr_y,
	input wire [DW-1:0] out_z, depth_wdata
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_take; s_axi_awvalid && s_axi_wvalid && s_axi_awready; endsequence
	sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
	property p_wr_resp; s_wr_take |=> s_axi_bvalid; endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write answer missing");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
	property p_b_busy; s_axi_bvalid |-> !s_axi_awready; endproperty
	a_b_busy: assert property (p_b_busy) else $error("write taken while answer pending");
	property p_rd_resp; s_rd_take |=> s_axi_rvalid; endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read answer missing");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
	property p_r_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_r_busy: assert property (p_r_busy) else $error("read taken while answer pending");
	property p_cause; out_valid || stencil_we || depth_we |-> $past(frag_valid); endproperty
	a_cause: assert property (p_cause) else $error("output without a fragment");
	property p_dwrite; depth_we |-> out_valid && depth_wdata == out_z; endproperty
	a_dwrite: assert property (p_dwrite) else $error("depth write for a dropped fragment");
	property p_dpos; depth_we |-> wr_x == out_x && wr_y == out_y; endproperty
	a_dpos: assert property (p_dpos) else $error("depth write at wrong pixel");
endmodule // sdou_chk
bind sdou_top sdou_chk #(.DW(DW), .XW(XW)) chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_wvalid,
	.s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_bresp, .s_axi_rdata, .frag_valid, .out_valid, .stencil_we, .depth_we,
	.out_x, .out_y, .wr_x, .wr_y, .out_z, .depth_wdata);

// file: sdou_fb_model.sv
// Purpose: Framebuffer holding stencil and depth for sixteen pixels
// Assumes: Pixel picked by the low four bits of x
// Notes:   Stencil starts at 0 to F, so both saturation ends come up
`timescale 1ns/1ps
module sdou_fb_model (
	// Clock and read side
	input wire          aclk,
	input wire [11:0]   rd_x,
	output logic [3:0]  sold,
	output logic [23:0] dold,
	// Write side
	input wire          stencil_we, depth_we,
	input wire [3:0]    stencil_wdata,
	input wire [23:0]   depth_wdata,
	input wire [11:0]   wr_x
);
	logic [3:0]  smem [16];
	logic [23:0] dmem [16];
	initial begin
		for (int i = 0; i < 16; i++) begin
			smem[i] = i[3:0];
			dmem[i] = {i[3:0], 20'h80000};
		end
	end
	assign sold = smem[rd_x[3:0]];
	assign dold = dmem[rd_x[3:0]];
	always @(posedge aclk) begin
		if (stencil_we) smem[wr_x[3:0]] <= stencil_wdata;
		if (depth_we) dmem[wr_x[3:0]] <= depth_wdata;
	end
endmodule // sdou_fb_model

// file: tb.sv
// Purpose: Self-checking bench for the stencil, depth and query stage
// Assumes: Stencil width 4; stored values come from the framebuffer model
// Notes:   Depth clamp is tried once with a fixed range, then stays off
`timescale 1ns/1ps
`include "sdou_defines.vh"
module tb;
	logic        aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic        s_axi_arvalid = '0, s_axi_rready = '0, frag_valid = '0, frag_polygon = '0, frag_back = '0;
	logic        upstream_idle = 1'h1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        frag_ready, out_valid, stencil_we, depth_we, early_tests, qon = '0;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd, seed = 32'h5B;
	logic [3:0]  s_axi_wstrb = 4'hF, frag_cover = '0, frag_stencil_old, out_cover, stencil_wdata;
	logic [11:0] frag_x = '0, frag_y = '0, out_x, out_y, wr_x, wr_y;
	logic [23:0] frag_z = '0, frag_depth_old, out_z, depth_wdata, dlo = 24'h000000, dhi = 24'hFFFFFF;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  sref [2] = '{8'h00, 8'h00}, smask [2] = '{8'hFF, 8'hFF};
	logic [2:0]  sfn [2] = '{3'h7, 3'h7}, sact [2][3] = '{default: 3'h0}, dfn = 3'h1;
	logic [6:0]  ctrl = 7'h18;
	int          fails = 0, n_compared = 0, qacc = 0;
	sdou_top #(.SW(4)) dut (.*);
	sdou_fb_model fb (.aclk, .rd_x(frag_x), .sold(frag_stencil_old), .dold(frag_depth_old), .stencil_we,
		.depth_we, .stencil_wdata, .depth_wdata, .wr_x);
	initial forever #50 aclk = ~aclk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic cmpf(logic [2:0] f, logic [23:0] a, logic [23:0] b);
		case (f)
			3'h0: return 1'h0;
			3'h1: return a < b;
			3'h2: return a == b;
			3'h3: return a <= b;
			3'h4: return a > b;
			3'h5: return a != b;
			3'h6: return a >= b;
			default: return 1'h1;
		endcase
	endfunction
	function automatic logic [3:0] actf(logic [2:0] a, logic [3:0] v, logic [3:0] r);
		case (a)
			3'h0: return v;
			3'h1: return 4'h0;
			3'h2: return r;
			3'h3: return (v == 4'hF) ? v : v + 4'h1;
			3'h4: return (v == 4'h0) ? v : v - 4'h1;
			3'h5: return ~v;
			3'h6: return v + 4'h1;
			default: return v - 4'h1;
		endcase
	endfunction
	function automatic logic [3:0] clampf(logic [7:0] r);
		return (r > 8'h0F) ? 4'hF : r[3:0];
	endfunction
	task automatic report_and_stop();
		$display("compared %0d mismatched %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			fails++;
		end
	endtask
	// Samples at the edge itself, before the design's updates land
	task automatic wait_hit(int k);
		for (int i = 0; i < 64; i++) begin
			@(posedge aclk);
			if (k == 0 ? s_axi_awready && s_axi_wready : k == 1 ? s_axi_bvalid : k == 2 ? s_axi_arready : s_axi_rvalid)
				return;
		end
		fails++;
		report_and_stop();
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		wait_hit(0);
		s_axi_awvalid <= 1'h0;
		s_axi_wvalid <= 1'h0;
		wait_hit(1);
		s_axi_bready <= 1'h0;
		chk("bresp", er, s_axi_bresp);
	endtask
	task automatic rd_reg(logic [7:0] a, logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		wait_hit(2);
		s_axi_arvalid <= 1'h0;
		wait_hit(3);
		s_axi_rready <= 1'h0;
		rd = s_axi_rdata;
		chk("rresp", er, s_axi_rresp);
	endtask
	task automatic rdc(logic [7:0] a, logic [31:0] m, logic [31:0] e);
		rd_reg(a, 2'h0);
		chk($sformatf("reg %h", a), e, rd & m);
	endtask
	task automatic configure();
		logic [31:0] r, q;
		logic [7:0]  rf, mk;
		logic [1:0]  sel;
		r = rnd();
		q = rnd();
		sel = (r[1:0] == 2'h0) ? 2'h3 : r[1:0];
		rf = {r[23:20] & {4{r[2]}}, r[19:16]};
		mk = r[3] ? 8'hFF : r[31:24];
		for (int f = 0; f < 2; f++) begin
			if (sel[f]) begin
				sfn[f] = r[10:8];
				sref[f] = rf;
				smask[f] = mk;
				sact[f] = '{q[2:0], q[5:3], q[8:6]};
			end
		end
		ctrl = {q[9], q[10], q[11] | q[12], q[13] | q[14], 1'h0, q[15], q[16]};
		dfn = q[19:17];
		wr(sel == 2'h2 ? `SDOU_REG_SFUNC_B : `SDOU_REG_SFUNC_F, {sel, 3'h0, r[10:8], rf, 8'h00, mk}, 2'h0);
		wr(sel == 2'h2 ? `SDOU_REG_SOP_B : `SDOU_REG_SOP_F, {sel, 21'h0, q[8:0]}, 2'h0);
		wr(`SDOU_REG_CTRL, {25'h0, ctrl}, 2'h0);
		chk("early_tests", ctrl[6], early_tests);
		wr(`SDOU_REG_DEPTH, {29'h0, dfn}, 2'h0);
		rdc(`SDOU_REG_SFUNC_F, 32'h07FF00FF, {5'h0, sfn[0], 4'h0, clampf(sref[0]), 12'h0, smask[0][3:0]});
		rdc(`SDOU_REG_SFUNC_B, 32'h07FF00FF, {5'h0, sfn[1], 4'h0, clampf(sref[1]), 12'h0, smask[1][3:0]});
	endtask
	task automatic frag();
		logic [31:0] r, z;
		logic        f, sp, dp, son, don;
		logic [3:0]  nv, rc, m;
		logic [23:0] zc;
		r = rnd();
		z = rnd();
		@(posedge aclk);
		frag_valid <= 1'h1;
		frag_x <= {8'h0, r[3:0]};
		frag_y <= r[15:4];
		frag_z <= {z[23:20], z[0] ? 20'h80000 : z[19:0]};
		frag_cover <= r[19:16];
		frag_polygon <= r[28];
		frag_back <= r[29];
		#1;
		f = frag_polygon && frag_back;
		son = ctrl[0] && ctrl[3];
		don = ctrl[1] && ctrl[4];
		m = smask[f][3:0];
		rc = clampf(sref[f]);
		sp = !son || cmpf(sfn[f], {20'h0, rc & m}, {20'h0, frag_stencil_old & m});
		zc = !ctrl[2] ? frag_z : (frag_z < dlo) ? dlo : (frag_z > dhi) ? dhi : frag_z;
		dp = !don || cmpf(dfn, zc, frag_depth_old);
		nv = actf(!sp ? sact[f][0] : !dp ? sact[f][1] : sact[f][2], frag_stencil_old, rc);
		if (qon && sp && dp)
			qacc += ctrl[5] ? $countones(frag_cover) : 1;
		@(posedge aclk);
		frag_valid <= 1'h0;
		#1;
		chk("out_valid", sp && dp, out_valid);
		chk("stencil_we", son && nv != frag_stencil_old, stencil_we);
		if (son && nv != frag_stencil_old)
			chk("stencil_wdata", nv, stencil_wdata);
		chk("depth_we", sp && dp && don, depth_we);
		chk("frag_ready", 32'h1, frag_ready);
		if (sp && dp) begin
			chk("out_z", zc, out_z);
			chk("out_x", frag_x, out_x);
			chk("out_y", frag_y, out_y);
			chk("out_cover", frag_cover, out_cover);
		end
		if (sp && dp && don)
			chk("wr_y", frag_y, wr_y);
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		rdc(`SDOU_REG_CTRL, 32'h7F, 32'h18);
		rdc(`SDOU_REG_SFUNC_F, 32'h07FF00FF, 32'h0700000F);
		rdc(`SDOU_REG_SFUNC_B, 32'h07FF00FF, 32'h0700000F);
		rdc(`SDOU_REG_SOP_F, 32'h1FF, 32'h0);
		rdc(`SDOU_REG_SOP_B, 32'h1FF, 32'h0);
		rdc(`SDOU_REG_DEPTH, 32'h7, 32'h1);
		rdc(`SDOU_REG_STCFG, 32'hFF, 32'h4);
		$display("reset value test done");
		wr(8'h3C, 32'h0, `SDOU_RESP_SLVERR);
		rd_reg(8'h3C, `SDOU_RESP_SLVERR);
		$display("unmapped access test done");
		wr(`SDOU_REG_RANGE, 32'h40009000, 2'h0);
		rdc(`SDOU_REG_RANGE, 32'hFFFFFFFF, 32'h40009000);
		dlo = 24'h400000;
		dhi = 24'h900000;
		ctrl = 7'h16;
		wr(`SDOU_REG_CTRL, {25'h0, ctrl}, 2'h0);
		repeat (8) frag();
		$display("depth clamp test done");
		for (int k = 0; k < 3; k++) begin
			wr(`SDOU_REG_QCMD, {28'h0, k[1:0], 2'h1}, 2'h0);
			qacc = 0;
			qon = 1'h1;
			repeat (12) begin
				configure();
				repeat (4) frag();
			end
			qon = 1'h0;
			@(posedge aclk);
			upstream_idle <= 1'h0;
			wr(`SDOU_REG_QCMD, {28'h0, k[1:0], 2'h2}, 2'h0);
			repeat (3) @(posedge aclk);
			rd_reg(`SDOU_REG_QSTAT, 2'h0);
			chk("held while busy", 32'h0, {31'h0, rd[0]});
			upstream_idle <= 1'h1;
			for (int i = 0; i < 20 && !rd[0]; i++)
				rd_reg(`SDOU_REG_QSTAT, 2'h0);
			chk("available", 32'h1, {31'h0, rd[0]});
			rd_reg(`SDOU_REG_QRESULT, 2'h0);
			chk("result", k == 0 ? qacc : {31'h0, qacc != 0}, rd);
			$display("query kind %0d test done", k);
		end
		report_and_stop();
	end
endmodule // tb
